// [logic/param_nvram_access.sv]
// access logic for the parameter memory: decode, strobes, recall and store
`timescale 1ns/1ps
`include "param_nvram_params.svh"
module param_nvram_access (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic init_n,
  input wire logic power_down,
  input wire logic param_mem_select_n,
  input wire logic column_strobe_n,
  input wire logic rd,
  input wire logic [`NV_IO_WIDTH-1:0] io_addr,
  input wire logic [`NV_AW:1] latched_addr,
  input wire logic [`NV_DW-1:0] data_in,
  output logic [`NV_IO_WIDTH-1:0] data_out,
  output logic data_oe,
  output logic chip_select,
  output logic store_strobe,
  output logic busy
);
  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: every pin but clk_sys and resetn passes two flops
  localparam int SW = `NV_CTRL_PINS + `NV_AW + `NV_DW + `NV_IO_WIDTH;
  logic [SW-1:0] pins, sync1_q, sync2_q;
  logic init_s_n, pwr_s, sel_s_n, cas_s_n, rd_s, stsel_s_n;
  logic [`NV_AW:1] la_s;
  logic [`NV_DW-1:0] din_s;
  logic [`NV_IO_WIDTH-1:0] ioa_s;

  assign pins = {init_n, power_down, param_mem_select_n, column_strobe_n, rd,
                 latched_addr, data_in, io_addr};

  // flops reset to ones: selects idle high and power counts as down until sampled,
  // so nothing can strobe on the leftovers of reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  assign {init_s_n, pwr_s, sel_s_n, cas_s_n, rd_s} = sync2_q[SW-1 -: `NV_CTRL_PINS];
  assign la_s = sync2_q[`NV_AW+`NV_DW+`NV_IO_WIDTH-1 -: `NV_AW];
  assign din_s = sync2_q[`NV_DW+`NV_IO_WIDTH-1 -: `NV_DW];
  assign ioa_s = sync2_q[`NV_IO_WIDTH-1:0];

  // decoded from the synchronised address, so the decode never reads a raw pin
  assign stsel_s_n = (ioa_s != `NV_STORE_IO_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    param_nvram_pkg::phase_type phase;
    logic [`NV_AW-1:0] cnt;
    logic cs;
    logic strobe;
    logic busy;
    logic oe;
    logic [`NV_DW-1:0] rdata;
    logic prev_cs;
  } state_type;

  state_type s_q, s_d;
  logic [`NV_DW-1:0] ram_rdata;
  logic cs_now, strobe_now, ram_we;

  assign cs_now = !sel_s_n && !cas_s_n;
  assign strobe_now = !stsel_s_n && !la_s[`NV_AW] && !pwr_s;
  // write only on the first chip-select cycle, so a long strobe writes once
  assign ram_we = cs_now && !s_q.prev_cs && !rd_s && s_q.phase == param_nvram_pkg::st_idle;

  always_comb begin
    s_d = s_q;
    s_d.prev_cs = cs_now;
    s_d.cs = cs_now && s_q.phase == param_nvram_pkg::st_idle;
    s_d.strobe = strobe_now;
    s_d.oe = cs_now && rd_s && s_q.phase == param_nvram_pkg::st_idle;
    s_d.rdata = ram_rdata;
    case (s_q.phase)
      param_nvram_pkg::st_recall: begin
        // the copy is gated off while power is low, so the count waits as well
        // and no location is left unrecalled
        if (pwr_s) begin
          s_d.cnt = s_q.cnt;
        end else if (s_q.cnt == `NV_LAST_ADDR) begin
          if (init_s_n) begin
            s_d.phase = param_nvram_pkg::st_idle;
          end
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      param_nvram_pkg::st_idle: begin
        if (!init_s_n) begin
          s_d.phase = param_nvram_pkg::st_recall;
          s_d.cnt = '0;
        end else if (strobe_now && !s_q.strobe) begin
          s_d.phase = param_nvram_pkg::st_store;
          s_d.cnt = '0;
        end
      end
      param_nvram_pkg::st_store: begin
        // power loss mid-copy aborts; a partial store beats a corrupt one
        if (pwr_s || s_q.cnt == `NV_LAST_ADDR) begin
          s_d.phase = param_nvram_pkg::st_idle;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      default: s_d.phase = param_nvram_pkg::st_idle;
    endcase
    s_d.busy = s_d.phase != param_nvram_pkg::st_idle;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{phase: param_nvram_pkg::st_recall, cnt: '0, cs: 1'b0, strobe: 1'b0,
               busy: 1'b1, oe: 1'b0, rdata: `NV_DATA_RST, prev_cs: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory
  param_nvram_cell u_cell (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ram_we(ram_we),
    .ram_addr(la_s[`NV_AW:1]),
    .ram_wdata(din_s),
    .ram_rdata(ram_rdata),
    .recall_en(s_q.phase == param_nvram_pkg::st_recall && !pwr_s),
    .store_en(s_q.phase == param_nvram_pkg::st_store && !pwr_s),
    .copy_addr(s_q.cnt)
  );

  assign chip_select = s_q.cs;
  assign store_strobe = s_q.strobe;
  assign busy = s_q.busy;
  assign data_oe = s_q.oe;
  assign data_out = {`NV_DATA_HI_FILL, s_q.rdata};

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // decode and strobes
  chk_cs_decode: assert property (@(posedge clk_sys) disable iff (!resetn)
    chip_select |-> $past(!sel_s_n && !cas_s_n))
    else $error("chip select without select and strobe");
  chk_store_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
    store_strobe |-> $past(!stsel_s_n && !la_s[`NV_AW]))
    else $error("store strobe without decode");
  chk_strobe_level: assert property (@(posedge clk_sys) disable iff (!resetn)
    strobe_now |=> store_strobe)
    else $error("store strobe missing after decode");
  chk_pwr_block: assert property (@(posedge clk_sys) disable iff (!resetn)
    pwr_s |=> !store_strobe)
    else $error("store strobe during power down");

  // ram transfers
  chk_cs_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
    chip_select |-> $past(s_q.phase) == param_nvram_pkg::st_idle)
    else $error("chip select during copy");
  chk_busy_no_cs: assert property (@(posedge clk_sys) disable iff (!resetn)
    busy |=> !chip_select)
    else $error("chip select while busy");
  chk_busy_no_oe: assert property (@(posedge clk_sys) disable iff (!resetn)
    busy |=> !data_oe)
    else $error("output enable while busy");
  chk_read_oe: assert property (@(posedge clk_sys) disable iff (!resetn)
    data_oe |-> $past(rd_s) && chip_select)
    else $error("output enable without read");
  chk_we_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
    ram_we |-> !sel_s_n && !cas_s_n && !rd_s)
    else $error("write without select, strobe and write level");
  chk_write_once: assert property (@(posedge clk_sys) disable iff (!resetn)
    ram_we |=> !ram_we)
    else $error("repeated write in one strobe");
  chk_hi_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
    data_out[`NV_IO_WIDTH-1:`NV_DW] == '0)
    else $error("upper data bits not zero");

  // store copy
  chk_store_start: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_q.phase == param_nvram_pkg::st_idle && init_s_n && strobe_now && !s_q.strobe)
    |=> busy)
    else $error("store strobe did not start copy");
  chk_copy_step: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_q.phase == param_nvram_pkg::st_store && !pwr_s && s_q.cnt != `NV_LAST_ADDR)
    |=> s_q.cnt == $past(s_q.cnt) + 8'h01)
    else $error("store copy skipped a location");
  chk_store_len: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_q.phase == param_nvram_pkg::st_idle && s_d.phase == param_nvram_pkg::st_store
     && !pwr_s) |=> (busy && !pwr_s)[*8] |-> ##[1:260] !busy)
    else $error("store copy did not finish");
  chk_store_abort: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_q.phase == param_nvram_pkg::st_store && pwr_s) |=> !busy)
    else $error("store copy not aborted on power down");

  // recall copy
  chk_recall_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    !init_s_n |=> busy)
    else $error("init did not start recall");
  chk_init_recall: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_q.phase == param_nvram_pkg::st_idle && !init_s_n)
    |=> s_q.phase == param_nvram_pkg::st_recall && s_q.cnt == '0)
    else $error("recall did not start at the first location");
  chk_recall_wait: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_q.phase == param_nvram_pkg::st_recall && pwr_s) |=> s_q.cnt == $past(s_q.cnt))
    else $error("recall moved on while power was down");
  chk_recall_done: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_q.phase == param_nvram_pkg::st_recall && !pwr_s && init_s_n
     && s_q.cnt == `NV_LAST_ADDR) |=> !busy)
    else $error("recall did not end after the last location");

  // scenario covers
  cov_read: cover property (@(posedge clk_sys) data_oe);
  cov_write: cover property (@(posedge clk_sys) ram_we);
  cov_store: cover property (@(posedge clk_sys) store_strobe ##1 busy);
  cov_recall_end: cover property (@(posedge clk_sys) busy ##1 !busy);
  cov_store_abort: cover property (@(posedge clk_sys)
    s_q.phase == param_nvram_pkg::st_store && pwr_s);
endmodule // param_nvram_access

// [common/param_nvram_params.svh]
// constants for the parameter memory access block
//
// Behaviour
// - 256 by 4 RAM with nonvolatile shadow
// - init low recalls shadow into RAM
// - store strobe needs store select and bit8 low
// - store copies whole RAM into shadow unless power-down is sensed mid-copy
// - power-down sensed suppresses store strobe
// - chip select needs memory select and column strobe
// - chip select gates only RAM transfers
// - read high selects read, address bits 1-8
// - read low writes nibble at address
// - store select decoded from octal 170140
`ifndef PARAM_NVRAM_PARAMS_SVH
`define PARAM_NVRAM_PARAMS_SVH
`define NV_DEPTH 256
`define NV_AW 8
`define NV_DW 4
`define NV_LAST_ADDR 8'hFF
`define NV_DATA_RST 4'h0
`define NV_IO_WIDTH 16
// octal 170140 on the processor I/O map
`define NV_STORE_IO_ADDR 16'hF060
// single-bit control pins ahead of the address, data and I/O address in the sync word
`define NV_CTRL_PINS 5
`define NV_DATA_HI_FILL 12'h000
`endif

// [common/param_nvram_pkg.sv]
// types for the parameter memory access block
package param_nvram_pkg;
  typedef enum logic [1:0] {st_recall, st_idle, st_store} phase_type;
endpackage

// [logic/param_nvram_cell.sv]
// 256 x 4 ram with nonvolatile shadow array and bulk copy ports
`timescale 1ns/1ps
`include "param_nvram_params.svh"
module param_nvram_cell (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ram_we,
  input wire logic [`NV_AW-1:0] ram_addr,
  input wire logic [`NV_DW-1:0] ram_wdata,
  output logic [`NV_DW-1:0] ram_rdata,
  input wire logic recall_en,
  input wire logic store_en,
  input wire logic [`NV_AW-1:0] copy_addr
);
  // arrays are not reset: the shadow models retained contents
  logic [`NV_DW-1:0] ram_mem [`NV_DEPTH];
  logic [`NV_DW-1:0] shadow_mem [`NV_DEPTH];

  always_ff @(posedge clk_sys) begin
    if (recall_en) begin
      ram_mem[copy_addr] <= shadow_mem[copy_addr];
    end else if (ram_we) begin
      ram_mem[ram_addr] <= ram_wdata;
    end
    if (store_en) begin
      shadow_mem[copy_addr] <= ram_mem[copy_addr];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ram_rdata <= `NV_DATA_RST;
    end else begin
      ram_rdata <= ram_mem[ram_addr];
    end
  end
endmodule // param_nvram_cell

// [verif/host_bus_model.sv]
// processor side model: drives the multiplexed bus levels into the block
`timescale 1ns/1ps
module host_bus_model (
  input wire logic clk_sys,
  output logic sel_n,
  output logic cas_n,
  output logic rd,
  output logic [15:0] io_addr,
  output logic [8:1] addr,
  output logic [3:0] data
);
  initial begin
    sel_n = 1'b1;
    cas_n = 1'b1;
    rd = 1'b1;
    io_addr = 16'h0000;
    addr = 8'h00;
    data = 4'h0;
  end
  task automatic drive(input logic s, c, r, input logic [15:0] io, input logic [8:1] a,
                       input logic [3:0] d);
    @(posedge clk_sys);
    #1;
    sel_n = s;
    cas_n = c;
    rd = r;
    io_addr = io;
    addr = a;
    data = d;
  endtask
  // select and strobe go high, I/O address and data flip, so a stale value can never pass for a held one
  task automatic release_bus();
    sel_n = 1'b1;
    cas_n = 1'b1;
    io_addr = ~io_addr;
    data = ~data;
  endtask
endmodule // host_bus_model

// [verif/tb_param_nvram_access.sv]
// self-checking bench for the parameter memory access block
`timescale 1ns/1ps
module tb_param_nvram_access;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic init_n = 1'b1;
  logic power_down = 1'b0;
  logic sel_n, cas_n, rd, data_oe, chip_select, store_strobe, busy;
  logic [15:0] io_addr, data_out;
  logic [8:1] addr;
  logic [3:0] data;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  // inputs (select, strobe, read, address, nibble), then chip select, enable, read data
  typedef struct packed {
    logic s;
    logic c;
    logic r;
    logic [8:1] a;
    logic [3:0] d;
    logic cs;
    logic oe;
    logic [15:0] q;
  } row_type;
  row_type rows [12] = '{
    '{1'b0, 1'b0, 1'b0, 8'h00, 4'hA, 1'b1, 1'b0, 16'h0000},
    '{1'b0, 1'b0, 1'b0, 8'hFF, 4'h5, 1'b1, 1'b0, 16'h0000},
    '{1'b0, 1'b0, 1'b0, 8'h55, 4'hF, 1'b1, 1'b0, 16'h0000},
    '{1'b0, 1'b0, 1'b0, 8'hAA, 4'h3, 1'b1, 1'b0, 16'h0000},
    '{1'b0, 1'b1, 1'b0, 8'h55, 4'h0, 1'b0, 1'b0, 16'h0000},
    '{1'b1, 1'b0, 1'b0, 8'hAA, 4'h0, 1'b0, 1'b0, 16'h0000},
    '{1'b0, 1'b0, 1'b1, 8'h00, 4'h0, 1'b1, 1'b1, 16'h000A},
    '{1'b0, 1'b0, 1'b1, 8'hFF, 4'h0, 1'b1, 1'b1, 16'h0005},
    '{1'b0, 1'b0, 1'b1, 8'h55, 4'h0, 1'b1, 1'b1, 16'h000F},
    '{1'b0, 1'b0, 1'b1, 8'hAA, 4'h0, 1'b1, 1'b1, 16'h0003},
    '{1'b0, 1'b1, 1'b1, 8'h00, 4'h0, 1'b0, 1'b0, 16'h0000},
    '{1'b1, 1'b0, 1'b1, 8'h00, 4'h0, 1'b0, 1'b0, 16'h0000}
  };
  host_bus_model u_host_bus_model (.clk_sys(clk_sys), .sel_n(sel_n), .cas_n(cas_n), .rd(rd),
    .io_addr(io_addr), .addr(addr), .data(data));
  param_nvram_access u_param_nvram_access (.clk_sys(clk_sys), .resetn(resetn), .init_n(init_n),
    .power_down(power_down), .param_mem_select_n(sel_n), .column_strobe_n(cas_n), .rd(rd),
    .io_addr(io_addr), .latched_addr(addr), .data_in(data), .data_out(data_out),
    .data_oe(data_oe), .chip_select(chip_select), .store_strobe(store_strobe), .busy(busy));
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic check_flag(input logic got, exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_data(input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // drive a request and let the three-edge input lag plus read data settle
  task automatic acc(input logic s, c, r, input logic [15:0] io, input logic [8:1] a,
                     input logic [3:0] d);
    u_host_bus_model.drive(s, c, r, io, a, d);
    repeat (5) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 600 && busy !== 1'b0; i++) @(posedge clk_sys);
    #1;
    check_flag(busy, 1'b0);
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    check_flag(busy, 1'b1);
    check_flag(chip_select, 1'b0);
    resetn = 1'b1;
    wait_idle();
    $display("test reset done");
    foreach (rows[i]) begin
      acc(rows[i].s, rows[i].c, rows[i].r, 16'h0000, rows[i].a, rows[i].d);
      check_flag(chip_select, rows[i].cs);
      check_flag(data_oe, rows[i].oe);
      if (rows[i].oe) begin
        check_data(data_out, rows[i].q);
      end
      u_host_bus_model.release_bus();
    end
    $display("test rows done");
    acc(1'b1, 1'b1, 1'b1, 16'hF060, 8'h80, 4'h0);
    check_flag(store_strobe, 1'b0);
    u_host_bus_model.release_bus();
    power_down = 1'b1;
    acc(1'b1, 1'b1, 1'b1, 16'hF060, 8'h00, 4'h0);
    check_flag(store_strobe, 1'b0);
    u_host_bus_model.release_bus();
    power_down = 1'b0;
    acc(1'b1, 1'b1, 1'b1, 16'hF060, 8'h00, 4'h0);
    check_flag(store_strobe, 1'b1);
    check_flag(busy, 1'b1);
    u_host_bus_model.release_bus();
    // a write during the copy must be refused
    acc(1'b0, 1'b0, 1'b0, 16'h0000, 8'hFF, 4'hA);
    check_flag(chip_select, 1'b0);
    u_host_bus_model.release_bus();
    wait_idle();
    acc(1'b0, 1'b0, 1'b1, 16'h0000, 8'hFF, 4'h0);
    check_data(data_out, 16'h0005);
    u_host_bus_model.release_bus();
    $display("test store done");
    acc(1'b0, 1'b0, 1'b0, 16'h0000, 8'h00, 4'h5);
    u_host_bus_model.release_bus();
    init_n = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
    init_n = 1'b1;
    wait_idle();
    acc(1'b0, 1'b0, 1'b1, 16'h0000, 8'h00, 4'h0);
    check_data(data_out, 16'h000A);
    u_host_bus_model.release_bus();
    $display("test recall done");
    // reset in mid-run: the shadow survives and is recalled again
    acc(1'b0, 1'b0, 1'b0, 16'h0000, 8'h55, 4'h0);
    u_host_bus_model.release_bus();
    resetn = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check_flag(busy, 1'b1);
    check_flag(chip_select, 1'b0);
    check_flag(data_oe, 1'b0);
    check_data(data_out, 16'h0000);
    resetn = 1'b1;
    wait_idle();
    acc(1'b0, 1'b0, 1'b1, 16'h0000, 8'h55, 4'h0);
    check_data(data_out, 16'h000F);
    u_host_bus_model.release_bus();
    $display("test mid reset done");
    end_sim();
  end
endmodule // tb_param_nvram_access
